// ---- sbs_bus_sva.sv ----
// sbs_bus_sva.sv: checker for the ram bus between controller and memory
module sbs_bus_sva import sbs_pkg::*; #(
	parameter int REC_CYC = SBS_SLEEP_RECOVERY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cke_n,
	input wire logic advance_load_select,
	input wire logic write_n,
	input wire logic chip_sel_n,
	input wire logic flow_through_select_n,
	input wire logic sleep_request,
	input wire logic ft_drive_oe,
	input wire logic sleep_drive_oe,
	input wire logic dq_ctl_oe,
	input wire logic dq_dev_oe,
	input wire logic asleep,
	input wire logic recovering
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	logic load_ok;
	logic [7:0] rec_cnt_ff;

	assign load_ok = !cke_n && !advance_load_select && !chip_sel_n &&
		!sleep_request && !asleep;

	// length of each recovery run, judged when it ends
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rec_cnt_ff <= 8'h00;
		end else if (recovering) begin
			rec_cnt_ff <= rec_cnt_ff + 8'h01;
		end else begin
			rec_cnt_ff <= 8'h00;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_sleep_entry;
		$rose(sleep_request) ##1 sleep_request |-> !asleep ##1 asleep;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep state not reached two edges after request");

	property p_sleep_float;
		sleep_request |=> !dq_dev_oe;
	endproperty
	a_sleep_float: assert property (p_sleep_float)
		else $error("read bus still driven after sleep request");

	property p_asleep_hold;
		asleep && sleep_request |=> asleep && !dq_dev_oe;
	endproperty
	a_asleep_hold: assert property (p_asleep_hold)
		else $error("sleep left or bus driven while request high");

	property p_rec_start;
		$fell(sleep_request) && asleep |=> recovering;
	endproperty
	a_rec_start: assert property (p_rec_start)
		else $error("no recovery after sleep request fell");

	property p_rec_len;
		$fell(recovering) |-> rec_cnt_ff == 8'(REC_CYC);
	endproperty
	a_rec_len: assert property (p_rec_len)
		else $error("recovery length differs from setting");

	property p_pin_default;
		(ft_drive_oe || flow_through_select_n) &&
			(sleep_drive_oe || !sleep_request);
	endproperty
	a_pin_default: assert property (p_pin_default)
		else $error("undriven mode pin not at its default");

	property p_wr_pipe;
		load_ok && !write_n && flow_through_select_n |-> ##2 dq_ctl_oe;
	endproperty
	a_wr_pipe: assert property (p_wr_pipe)
		else $error("pipeline write data not two edges after command");

	property p_wr_flow;
		load_ok && !write_n && !flow_through_select_n |=> dq_ctl_oe;
	endproperty
	a_wr_flow: assert property (p_wr_flow)
		else $error("flow write data not one edge after command");

	property p_rd_pipe;
		load_ok && write_n && flow_through_select_n |-> ##2 dq_dev_oe;
	endproperty
	a_rd_pipe: assert property (p_rd_pipe)
		else $error("pipeline read data not through output register");

	property p_rd_flow;
		load_ok && write_n && !flow_through_select_n |=> dq_dev_oe;
	endproperty
	a_rd_flow: assert property (p_rd_flow)
		else $error("flow read data not driven after capture edge");

	property p_hold;
		cke_n && !sleep_request |=> $stable(dq_dev_oe);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read bus changed on a held edge");

	c_sleep: cover property (asleep);
	c_rec: cover property ($fell(recovering));
	c_hold: cover property (cke_n ##1 cke_n);
	c_flow_rd: cover property (load_ok && write_n && !flow_through_select_n);
endmodule : sbs_bus_sva

// ---- sbs_ctl.sv ----
// sbs_ctl.sv: controller end: register port to ram bus commands and data
module sbs_ctl import sbs_pkg::*; #(
	parameter int ADDR_W = SBS_ADDR_W,
	parameter int DATA_W = SBS_DATA_W,
	parameter int REC_CYC = SBS_SLEEP_RECOVERY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	sbs_if.ctl bus,
	input wire logic [SBS_REG_AW-1:0] reg_addr,
	input wire logic [SBS_REG_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [SBS_REG_DW-1:0] reg_rdata
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic [SBS_CTRL_W-1:0] ctrl_ff;
	logic [ADDR_W-1:0] start_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic rd_done_ff;
	logic refused_ff;
	logic [SBS_REG_DW-1:0] reg_rdata_ff;
	logic cke_n_ff, adv_ff, we_n_ff, ce_n_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic lbo_ff, ft_ff, ft_oe_ff, sleep_ff, sleep_oe_ff;
	logic [DATA_W-1:0] dq_ff;
	logic dq_oe_ff;
	sbs_op_t pin_op_ff, last_op_ff, v1_op_ff, v2_op_ff, cmd_op;
	logic [DATA_W-1:0] pin_data_ff, v1_data_ff, v2_data_ff;
	logic [SBS_CNT_W-1:0] rec_cnt_ff;
	logic cmd_wr, busy, recovering, refuse, issue, nxt_sleep, flow, step;
	logic [SBS_REG_DW-1:0] rd_val;

	function automatic logic hit(input logic [SBS_REG_AW-1:0] a,
		input logic [SBS_REG_AW-1:0] off);
		return a == off;
	endfunction : hit

	// --------------------------------------------------------------
	// command acceptance
	// --------------------------------------------------------------
	assign cmd_wr = reg_wr && hit(reg_addr, SBS_REG_CMD);
	assign cmd_op = reg_wdata[SBS_CMD_ADVANCE] ? last_op_ff :
		(reg_wdata[SBS_CMD_WRITE] ? SBS_OP_WRITE : SBS_OP_READ);
	assign busy = pin_op_ff != SBS_OP_NONE || v1_op_ff != SBS_OP_NONE ||
		v2_op_ff != SBS_OP_NONE;
	assign recovering = rec_cnt_ff != '0;
	assign refuse = ctrl_ff[SBS_CTRL_SLEEP] || sleep_ff ||
		ctrl_ff[SBS_CTRL_HOLD] ||
		(cmd_op == SBS_OP_WRITE && recovering);
	assign issue = cmd_wr && !refuse;
	// sleep pin rises only once nothing is in flight
	assign nxt_sleep = ctrl_ff[SBS_CTRL_SLEEP] && (sleep_ff || !busy);
	assign flow = ft_oe_ff && !ft_ff;
	assign step = !cke_n_ff;

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= '0;
			start_ff <= '0;
			wdata_ff <= '0;
		end else if (reg_wr) begin
			if (hit(reg_addr, SBS_REG_CTRL)) begin
				ctrl_ff <= reg_wdata[SBS_CTRL_W-1:0];
			end
			if (hit(reg_addr, SBS_REG_ADDR)) begin
				start_ff <= reg_wdata[ADDR_W-1:0];
			end
			if (hit(reg_addr, SBS_REG_WDATA)) begin
				wdata_ff <= reg_wdata[DATA_W-1:0];
			end
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_done_ff <= 1'h0;
			refused_ff <= 1'h0;
			rdata_ff <= '0;
		end else begin
			if (step && (flow ? v1_op_ff : v2_op_ff) == SBS_OP_READ) begin
				rdata_ff <= bus.dq;
				rd_done_ff <= 1'h1;
			end else if (reg_wr && hit(reg_addr, SBS_REG_STATUS) &&
				reg_wdata[SBS_ST_RD_DONE]) begin
				rd_done_ff <= 1'h0;
			end
			if (cmd_wr && refuse) begin
				refused_ff <= 1'h1;
			end else if (reg_wr && hit(reg_addr, SBS_REG_STATUS) &&
				reg_wdata[SBS_ST_REFUSED]) begin
				refused_ff <= 1'h0;
			end
		end
	end

	always_comb begin
		rd_val = '0;
		case (reg_addr)
			SBS_REG_CTRL: rd_val[SBS_CTRL_W-1:0] = ctrl_ff;
			SBS_REG_ADDR: rd_val[ADDR_W-1:0] = start_ff;
			SBS_REG_WDATA: rd_val[DATA_W-1:0] = wdata_ff;
			SBS_REG_RDATA: rd_val[DATA_W-1:0] = rdata_ff;
			SBS_REG_STATUS: begin
				rd_val[SBS_ST_BUSY] = busy;
				rd_val[SBS_ST_RD_DONE] = rd_done_ff;
				rd_val[SBS_ST_REFUSED] = refused_ff;
				rd_val[SBS_ST_SLEEP] = sleep_ff;
				rd_val[SBS_ST_RECOVER] = recovering;
			end
			default: rd_val = '0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_ff <= '0;
		end else begin
			reg_rdata_ff <= reg_rd ? rd_val : '0;
		end
	end

	// --------------------------------------------------------------
	// pins, sleep and recovery
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cke_n_ff <= 1'h0;
			lbo_ff <= 1'h0;
			ft_ff <= 1'h1;
			ft_oe_ff <= 1'h0;
			sleep_ff <= 1'h0;
			sleep_oe_ff <= 1'h0;
			rec_cnt_ff <= '0;
		end else begin
			cke_n_ff <= ctrl_ff[SBS_CTRL_HOLD];
			lbo_ff <= ctrl_ff[SBS_CTRL_INTERLEAVE];
			ft_ff <= !ctrl_ff[SBS_CTRL_FLOW];
			ft_oe_ff <= !ctrl_ff[SBS_CTRL_FLOAT];
			sleep_ff <= nxt_sleep;
			sleep_oe_ff <= nxt_sleep || !ctrl_ff[SBS_CTRL_FLOAT];
			if (sleep_ff && !nxt_sleep) begin
				rec_cnt_ff <= SBS_CNT_W'(REC_CYC);
			end else if (recovering) begin
				rec_cnt_ff <= rec_cnt_ff - SBS_CNT_W'(1);
			end
		end
	end

	// idle cycles are deselect loads, so a continue must follow at once
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			adv_ff <= 1'h0;
			we_n_ff <= 1'h1;
			ce_n_ff <= 1'h1;
			addr_ff <= '0;
			pin_op_ff <= SBS_OP_NONE;
			pin_data_ff <= '0;
			last_op_ff <= SBS_OP_NONE;
		end else if (issue) begin
			adv_ff <= reg_wdata[SBS_CMD_ADVANCE];
			we_n_ff <= cmd_op != SBS_OP_WRITE;
			ce_n_ff <= 1'h0;
			addr_ff <= start_ff;
			pin_op_ff <= cmd_op;
			pin_data_ff <= wdata_ff;
			last_op_ff <= cmd_op;
		end else begin
			adv_ff <= 1'h0;
			we_n_ff <= 1'h1;
			ce_n_ff <= 1'h1;
			pin_op_ff <= SBS_OP_NONE;
			last_op_ff <= SBS_OP_NONE;
		end
	end

	// --------------------------------------------------------------
	// data phase tracking
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			v1_op_ff <= SBS_OP_NONE;
			v2_op_ff <= SBS_OP_NONE;
			v1_data_ff <= '0;
			v2_data_ff <= '0;
			dq_ff <= '0;
			dq_oe_ff <= 1'h0;
		end else if (step) begin
			v1_op_ff <= pin_op_ff;
			v1_data_ff <= pin_data_ff;
			v2_op_ff <= v1_op_ff;
			v2_data_ff <= v1_data_ff;
			if (flow ? pin_op_ff == SBS_OP_WRITE : v1_op_ff == SBS_OP_WRITE) begin
				dq_ff <= flow ? pin_data_ff : v1_data_ff;
				dq_oe_ff <= 1'h1;
			end else begin
				dq_oe_ff <= 1'h0;
			end
		end
	end

	assign bus.cke_n = cke_n_ff;
	assign bus.advance_load_select = adv_ff;
	assign bus.write_n = we_n_ff;
	assign bus.chip_sel_n = ce_n_ff;
	assign bus.addr = addr_ff;
	assign bus.burst_order_select_n = lbo_ff;
	assign bus.ft_drive = ft_ff;
	assign bus.ft_drive_oe = ft_oe_ff;
	assign bus.sleep_drive = sleep_ff;
	assign bus.sleep_drive_oe = sleep_oe_ff;
	assign bus.dq_ctl = dq_ff;
	assign bus.dq_ctl_oe = dq_oe_ff;
	assign reg_rdata = reg_rdata_ff;

endmodule : sbs_ctl

// ---- sbs_dev.sv ----
// sbs_dev.sv: memory end: burst counter, mode pins, sleep and data pipeline
module sbs_dev import sbs_pkg::*; #(
	parameter int ADDR_W = SBS_ADDR_W,
	parameter int DATA_W = SBS_DATA_W,
	parameter int REC_CYC = SBS_SLEEP_RECOVERY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	sbs_if.dev bus,
	output logic asleep,
	output logic recovering
);

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	localparam int DEPTH = 1 << ADDR_W;

	sbs_sleep_t state_ff;
	sbs_sleep_t nxt_state;
	logic [SBS_CNT_W-1:0] cnt_ff;
	logic [SBS_CNT_W-1:0] nxt_cnt;
	logic asleep_ff;
	logic recovering_ff;

	logic [ADDR_W-1:0] base_ff;
	logic [SBS_BURST_W-1:0] bcnt_ff;
	logic [SBS_BURST_W-1:0] nxt_bcnt;
	sbs_op_t bop_ff;

	sbs_op_t s1_op_ff;
	sbs_op_t s2_op_ff;
	logic [ADDR_W-1:0] s1_addr_ff;
	logic [ADDR_W-1:0] s2_addr_ff;

	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] dq_out_ff;
	logic dq_oe_ff;

	logic flow;
	logic interleave;
	logic load;
	logic step;
	logic write_ok;
	logic sleeping;
	sbs_op_t load_op;
	sbs_op_t cur_op;
	logic [ADDR_W-1:0] cur_addr;
	logic wr_hit;
	logic [ADDR_W-1:0] wr_addr;
	logic rd_hit;
	logic [ADDR_W-1:0] rd_addr;

	// --------------------------------------------------------------
	// mode pins
	// --------------------------------------------------------------
	// pulls live in the interface, so an open pin reads pipeline/awake
	assign flow = !bus.flow_through_select_n;
	assign interleave = bus.burst_order_select_n;

	// --------------------------------------------------------------
	// sleep control
	// --------------------------------------------------------------
	// the raw pin gates acceptance at once; only the state needs edges
	assign sleeping = bus.sleep_request || state_ff == SBS_ASLEEP;
	assign step = !bus.cke_n && !sleeping;
	assign write_ok = state_ff != SBS_RECOVER;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			SBS_AWAKE: begin
				if (bus.sleep_request) begin
					nxt_state = SBS_ENTERING;
					nxt_cnt = SBS_CNT_W'(1);
				end
			end
			SBS_ENTERING: begin
				if (!bus.sleep_request) begin
					nxt_state = SBS_AWAKE;
				end else if (cnt_ff >= SBS_CNT_W'(SBS_SLEEP_ENTRY_CYC - 1)) begin
					nxt_state = SBS_ASLEEP;
				end else begin
					nxt_cnt = cnt_ff + SBS_CNT_W'(1);
				end
			end
			SBS_ASLEEP: begin
				if (!bus.sleep_request) begin
					nxt_state = SBS_RECOVER;
					nxt_cnt = '0;
				end
			end
			SBS_RECOVER: begin
				if (bus.sleep_request) begin
					nxt_state = SBS_ASLEEP;
				end else if (cnt_ff >= SBS_CNT_W'(REC_CYC - 1)) begin
					nxt_state = SBS_AWAKE;
				end else begin
					nxt_cnt = cnt_ff + SBS_CNT_W'(1);
				end
			end
			default: begin
				nxt_state = SBS_AWAKE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= SBS_AWAKE;
			cnt_ff <= '0;
			asleep_ff <= 1'h0;
			recovering_ff <= 1'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			asleep_ff <= nxt_state == SBS_ASLEEP;
			recovering_ff <= nxt_state == SBS_RECOVER;
		end
	end

	assign asleep = asleep_ff;
	assign recovering = recovering_ff;

	// --------------------------------------------------------------
	// burst address generation
	// --------------------------------------------------------------
	assign load = !bus.advance_load_select;
	assign nxt_bcnt = bcnt_ff + SBS_BURST_W'(1);
	assign load_op = bus.chip_sel_n ? SBS_OP_NONE :
		(bus.write_n ? SBS_OP_READ : SBS_OP_WRITE);

	always_comb begin
		if (load) begin
			cur_addr = bus.addr;
			cur_op = load_op;
		end else begin
			// upper bits stay from the loaded start
			cur_addr = {base_ff[ADDR_W-1:SBS_BURST_W],
				sbs_burst_lsb(base_ff[SBS_BURST_W-1:0], nxt_bcnt,
				interleave)};
			cur_op = bop_ff;
		end
		// writes during wake-up are dropped, reads still served
		if (cur_op == SBS_OP_WRITE && !write_ok) begin
			cur_op = SBS_OP_NONE;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			base_ff <= '0;
			bcnt_ff <= '0;
			bop_ff <= SBS_OP_NONE;
		end else if (step) begin
			if (load) begin
				base_ff <= bus.addr;
				bcnt_ff <= '0;
				bop_ff <= load_op;
			end else begin
				// two-bit count wraps to the start on the fifth access
				bcnt_ff <= nxt_bcnt;
			end
		end
	end

	// --------------------------------------------------------------
	// command pipeline
	// --------------------------------------------------------------
	// stages only move on accepted edges, so sleep and holds keep them
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_op_ff <= SBS_OP_NONE;
			s2_op_ff <= SBS_OP_NONE;
			s1_addr_ff <= '0;
			s2_addr_ff <= '0;
		end else if (step) begin
			s1_op_ff <= cur_op;
			s1_addr_ff <= cur_addr;
			s2_op_ff <= s1_op_ff;
			s2_addr_ff <= s1_addr_ff;
		end
	end

	// --------------------------------------------------------------
	// storage and data bus
	// --------------------------------------------------------------
	assign wr_hit = flow ? (s1_op_ff == SBS_OP_WRITE) :
		(s2_op_ff == SBS_OP_WRITE);
	assign wr_addr = flow ? s1_addr_ff : s2_addr_ff;
	assign rd_hit = flow ? (cur_op == SBS_OP_READ) :
		(s1_op_ff == SBS_OP_READ);
	assign rd_addr = flow ? cur_addr : s1_addr_ff;

	// contents are not reset; only control state is
	always_ff @(posedge sys_clk) begin
		if (step && wr_hit) begin
			mem[wr_addr] <= bus.dq;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			dq_out_ff <= '0;
			dq_oe_ff <= 1'h0;
		end else if (sleeping) begin
			dq_oe_ff <= 1'h0;
		end else if (step) begin
			if (rd_hit) begin
				dq_out_ff <= mem[rd_addr];
				dq_oe_ff <= 1'h1;
			end else begin
				dq_oe_ff <= 1'h0;
			end
		end
	end

	assign bus.dq_dev = dq_out_ff;
	assign bus.dq_dev_oe = dq_oe_ff;

endmodule : sbs_dev

// ---- sbs_if.sv ----
// sbs_if.sv: ram bus between controller and memory, with pin pulls
interface sbs_if import sbs_pkg::*; #(
	parameter int ADDR_W = SBS_ADDR_W,
	parameter int DATA_W = SBS_DATA_W
);
	logic cke_n;
	logic advance_load_select;
	logic write_n;
	logic chip_sel_n;
	logic [ADDR_W-1:0] addr;
	logic burst_order_select_n;
	logic ft_drive;
	logic ft_drive_oe;
	logic sleep_drive;
	logic sleep_drive_oe;
	logic flow_through_select_n;
	logic sleep_request;
	logic [DATA_W-1:0] dq_ctl;
	logic dq_ctl_oe;
	logic [DATA_W-1:0] dq_dev;
	logic dq_dev_oe;
	logic [DATA_W-1:0] dq;

	// pull-up on the flow-through pin, pull-down on the sleep pin
	assign flow_through_select_n = ft_drive_oe ? ft_drive : 1'h1;
	assign sleep_request = sleep_drive_oe ? sleep_drive : 1'h0;
	// undriven bus reads as zero
	assign dq = dq_dev_oe ? dq_dev : (dq_ctl_oe ? dq_ctl : '0);

	modport ctl (
		output cke_n, advance_load_select, write_n, chip_sel_n, addr,
		output burst_order_select_n, ft_drive, ft_drive_oe,
		output sleep_drive, sleep_drive_oe, dq_ctl, dq_ctl_oe,
		input flow_through_select_n, sleep_request, dq
	);
	modport dev (
		input cke_n, advance_load_select, write_n, chip_sel_n, addr,
		input burst_order_select_n, flow_through_select_n, sleep_request,
		input dq,
		output dq_dev, dq_dev_oe
	);
endinterface : sbs_if

// ---- sbs_pkg.sv ----
// sbs_pkg.sv: shared constants, types and helpers of the burst/sleep ram pair
package sbs_pkg;

	// --------------------------------------------------------------
	// widths
	// --------------------------------------------------------------
	localparam int SBS_ADDR_W = 8;
	localparam int SBS_DATA_W = 16;
	localparam int SBS_BURST_W = 2;
	localparam int SBS_CNT_W = 8;
	localparam int SBS_REG_AW = 8;
	localparam int SBS_REG_DW = 32;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int SBS_CLK_PERIOD_NS = 100;
	localparam int SBS_SLEEP_ENTRY_CYC = 2;
	localparam int SBS_SLEEP_RECOVERY_NS = 200;
	localparam int SBS_SLEEP_RECOVERY_CYC_RAW =
		(SBS_SLEEP_RECOVERY_NS + SBS_CLK_PERIOD_NS - 1) / SBS_CLK_PERIOD_NS;
	localparam int SBS_SLEEP_RECOVERY_CYC =
		(SBS_SLEEP_RECOVERY_CYC_RAW < 1) ? 1 : SBS_SLEEP_RECOVERY_CYC_RAW;

	// --------------------------------------------------------------
	// controller register map
	// --------------------------------------------------------------
	localparam logic [SBS_REG_AW-1:0] SBS_REG_CTRL = 8'h00;
	localparam logic [SBS_REG_AW-1:0] SBS_REG_ADDR = 8'h04;
	localparam logic [SBS_REG_AW-1:0] SBS_REG_WDATA = 8'h08;
	localparam logic [SBS_REG_AW-1:0] SBS_REG_CMD = 8'h0c;
	localparam logic [SBS_REG_AW-1:0] SBS_REG_RDATA = 8'h10;
	localparam logic [SBS_REG_AW-1:0] SBS_REG_STATUS = 8'h14;

	localparam int SBS_CTRL_W = 5;
	localparam int SBS_CTRL_INTERLEAVE = 0;
	localparam int SBS_CTRL_FLOW = 1;
	localparam int SBS_CTRL_SLEEP = 2;
	localparam int SBS_CTRL_HOLD = 3;
	localparam int SBS_CTRL_FLOAT = 4;
	localparam int SBS_CMD_WRITE = 0;
	localparam int SBS_CMD_ADVANCE = 1;
	localparam int SBS_ST_BUSY = 0;
	localparam int SBS_ST_RD_DONE = 1;
	localparam int SBS_ST_REFUSED = 2;
	localparam int SBS_ST_SLEEP = 3;
	localparam int SBS_ST_RECOVER = 4;

	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		SBS_OP_NONE = 2'h0,
		SBS_OP_READ = 2'h1,
		SBS_OP_WRITE = 2'h3
	} sbs_op_t;

	typedef enum logic [1:0] {
		SBS_AWAKE = 2'h0,
		SBS_ENTERING = 2'h1,
		SBS_ASLEEP = 2'h3,
		SBS_RECOVER = 2'h2
	} sbs_sleep_t;

	function automatic logic [SBS_BURST_W-1:0] sbs_burst_lsb(
		input logic [SBS_BURST_W-1:0] start,
		input logic [SBS_BURST_W-1:0] step,
		input logic interleave
	);
		return interleave ? (start ^ step) : SBS_BURST_W'(start + step);
	endfunction : sbs_burst_lsb

endpackage : sbs_pkg

// ---- tb_sram_burst_order_and_sleep_control.sv ----
// tb_sram_burst_order_and_sleep_control.sv: self-checking bench, both ends
module tb_sram_burst_order_and_sleep_control import sbs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int REC = 2;
	logic sys_clk;
	logic rst_b;
	logic [SBS_REG_AW-1:0] reg_addr;
	logic [SBS_REG_DW-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [SBS_REG_DW-1:0] reg_rdata;
	logic asleep;
	logic recovering;
	int mismatches;
	int tests_run;
	logic [31:0] rd_v;
	logic [15:0] mem_exp [0:255];

	sbs_if #(.ADDR_W(SBS_ADDR_W), .DATA_W(SBS_DATA_W)) sbs_if_i ();
	sbs_ctl #(.REC_CYC(REC)) sbs_ctl_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.bus(sbs_if_i.ctl), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sbs_dev #(.REC_CYC(REC)) sbs_dev_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.bus(sbs_if_i.dev), .asleep(asleep), .recovering(recovering));
	sbs_bus_sva #(.REC_CYC(REC)) sbs_bus_sva_i (.sys_clk(sys_clk),
		.rst_b(rst_b), .cke_n(sbs_if_i.cke_n),
		.advance_load_select(sbs_if_i.advance_load_select),
		.write_n(sbs_if_i.write_n), .chip_sel_n(sbs_if_i.chip_sel_n),
		.flow_through_select_n(sbs_if_i.flow_through_select_n),
		.sleep_request(sbs_if_i.sleep_request),
		.ft_drive_oe(sbs_if_i.ft_drive_oe),
		.sleep_drive_oe(sbs_if_i.sleep_drive_oe),
		.dq_ctl_oe(sbs_if_i.dq_ctl_oe), .dq_dev_oe(sbs_if_i.dq_dev_oe),
		.asleep(asleep), .recovering(recovering));

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// strobe stays up so writes can follow back to back
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		reg_rd <= 1'h0;
		@(posedge sys_clk);
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_wr <= 1'h0;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		@(negedge sys_clk);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask : reg_read

	task automatic wait_ready;
		logic [31:0] s;
		int n;
		s = 32'h1;
		n = 0;
		while (s[SBS_ST_BUSY] !== 1'h0 && n < 40) begin
			reg_read(SBS_REG_STATUS, s);
			n++;
		end
		check({31'h0, s[SBS_ST_BUSY]}, 32'h0);
	endtask : wait_ready

	task automatic mem_write(input logic [7:0] a, input logic [15:0] d);
		reg_write(SBS_REG_ADDR, {24'h0, a});
		reg_write(SBS_REG_WDATA, {16'h0, d});
		reg_write(SBS_REG_CMD, 32'h1);
		wait_ready();
		mem_exp[a] = d;
	endtask : mem_write

	// continues must follow the load with no gap or the burst ends
	task automatic burst_read(input logic [7:0] a, input int k,
		output logic [31:0] d);
		reg_write(SBS_REG_ADDR, {24'h0, a});
		reg_write(SBS_REG_CMD, 32'h0);
		repeat (k) reg_write(SBS_REG_CMD, 32'h2);
		wait_ready();
		reg_read(SBS_REG_RDATA, d);
	endtask : burst_read

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'h0;
		forever #50 sys_clk = ~sys_clk;
	end

	initial begin
		#2000000;
		mismatches++;
		finish_test();
	end

	initial begin
		logic [1:0] e;
		rst_b = 1'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		mismatches = 0;
		tests_run = 0;
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'h1;
		@(posedge sys_clk);
		reg_read(SBS_REG_CTRL, rd_v);
		check(rd_v, 32'h0);
		reg_write(8'h18, 32'hffff_ffff);
		reg_read(8'h18, rd_v);
		check(rd_v, 32'h0);
		for (int m = 0; m < 4; m++) begin
			reg_write(SBS_REG_CTRL, 32'(m));
			for (int i = 0; i < 8; i++) begin
				mem_write(8'h34 + 8'(i), {4'ha, 4'(m), 8'h34 + 8'(i)});
			end
			check({31'h0, sbs_if_i.flow_through_select_n},
				{31'h0, !m[1]});
			// wrong carry into bit 2 would hit the 0x38 row
			for (int k = 0; k < 5; k++) begin
				burst_read(8'h35, k, rd_v);
				e = m[0] ? (2'h1 ^ 2'(k)) : 2'(2'h1 + 2'(k));
				check(rd_v, {16'h0, mem_exp[{6'h0d, e}]});
			end
		end
		reg_write(SBS_REG_CTRL, 32'h8);
		reg_write(SBS_REG_CMD, 32'h1);
		reg_read(SBS_REG_STATUS, rd_v);
		check(rd_v & 32'h4, 32'h4);
		check({31'h0, sbs_if_i.cke_n}, 32'h1);
		reg_write(SBS_REG_STATUS, 32'h4);
		reg_write(SBS_REG_CTRL, 32'h4);
		reg_read(SBS_REG_STATUS, rd_v);
		reg_read(SBS_REG_STATUS, rd_v);
		check(rd_v & 32'hc, 32'h8);
		// asleep rose one edge back, during the last status read; look half a cycle on, clear of this edge
		@(negedge sys_clk);
		check({30'h0, asleep, sbs_if_i.dq_dev_oe}, 32'h2);
		@(posedge sys_clk);
		reg_write(SBS_REG_CMD, 32'h1);
		reg_read(SBS_REG_STATUS, rd_v);
		check(rd_v & 32'h4, 32'h4);
		// wake first, so the write lands inside recovery, not sleep
		reg_write(SBS_REG_CTRL, 32'h0);
		reg_write(SBS_REG_STATUS, 32'h4);
		reg_write(SBS_REG_CMD, 32'h1);
		reg_read(SBS_REG_STATUS, rd_v);
		check(rd_v & 32'h14, 32'h14);
		wait_ready();
		burst_read(8'h35, 0, rd_v);
		check(rd_v, {16'h0, mem_exp[8'h35]});
		mem_write(8'h37, 16'h5a5a);
		burst_read(8'h37, 0, rd_v);
		check(rd_v, 32'h5a5a);
		reg_write(SBS_REG_CTRL, 32'h10);
		reg_read(SBS_REG_CTRL, rd_v);
		check({30'h0, sbs_if_i.flow_through_select_n,
			sbs_if_i.sleep_request}, 32'h2);
		burst_read(8'h36, 0, rd_v);
		check(rd_v, {16'h0, mem_exp[8'h36]});
		finish_test();
	end
endmodule : tb_sram_burst_order_and_sleep_control
